// ==== rtl/mtc_pkg.sv ====
// Package for the memory table copy controller: register map, field
// layout, limits and enumerations.
// Assumes an APB master with 32-bit data and word-aligned registers.
package mtc_pkg;
  localparam int MTC_ENTRY_W = 7;
  localparam int MTC_DATA_W = 32;
  localparam int MTC_WORDS = 16;
  localparam int MTC_WIDX_W = 4;
  localparam logic [7:0] MTC_MAX_ENTRY = 8'h7F;
  // Register byte offsets.
  localparam logic [11:0] MTC_A_CTYPE = 12'h000;
  localparam logic [11:0] MTC_A_DEST = 12'h004;
  localparam logic [11:0] MTC_A_SRC = 12'h008;
  localparam logic [11:0] MTC_A_STATUS = 12'h00C;
  localparam logic [11:0] MTC_A_TSEL = 12'h010;
  localparam logic [11:0] MTC_A_TDATA = 12'h014;
  localparam logic [11:0] MTC_A_INDIR = 12'h018;
  localparam logic [11:0] MTC_A_DISP = 12'h01C;
  // Field layout and values.
  localparam logic [3:0] MTC_CT_STRING = 4'h0;
  localparam logic [3:0] MTC_CT_NUMERAL = 4'h1;
  localparam logic [15:0] MTC_CTYPE_RST = 16'h9999;
  localparam int MTC_ST_BUSY = 0;
  localparam int MTC_ST_DONE = 1;
  localparam int MTC_ST_BADREQ = 2;
  localparam int MTC_ST_REFRESH = 3;
  localparam int MTC_ST_INDBAD = 4;
  localparam int MTC_TSEL_KIND = 11;
  typedef enum logic [1:0] {
    MTC_IDLE,
    MTC_COPY,
    MTC_REFRESH
  } mtc_state_t;
endpackage

// ==== rtl/mtc_copy_ctrl.sv ====
// Memory table copy controller: holds string and numeral tables, watches
// the terminal control area and copies one entry to another on change.
// Assumes a single APB master on pclk; pready answers in the access cycle.
`timescale 1ns/1ps

// Operation
// - Copy type 0 strings, 1 numerals.
// - Entry numbers lie in 000 to 127.
// - No copy for other copy types.
// - Copy only when request contents change.
// - Area may be sampled mid-update.
// - Copy source to destination, then refresh display.
// - Fetch only displayed entries, others at initialization.
// - Incompatible numeral entries may copy wrongly.
// - Indirect number BCD 0-127, else keep display.
module mtc_copy_ctrl
  import mtc_pkg::*;
#(
  parameter int ENTRIES = 128
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic disp_refresh,
  output logic [6:0] disp_entry,
  output logic disp_kind
);

  // BCD of three digits to binary; flags hex digits and out-of-range.
  function automatic logic [8:0] bcd_decode(input logic [11:0] v);
    logic [9:0] n;
    logic ok;
    ok = (v[11:8] < 4'hA) && (v[7:4] < 4'hA) && (v[3:0] < 4'hA);
    n = 10'(v[11:8]) * 10'd100 + 10'(v[7:4]) * 10'd10 + 10'(v[3:0]);
    if (n > 10'(MTC_MAX_ENTRY)) begin
      ok = 1'b0;
    end
    return {ok, n[7:0]};
  endfunction

  logic [31:0] str_mem_r [ENTRIES][MTC_WORDS];
  logic [31:0] str_mem_nxt [ENTRIES][MTC_WORDS];
  logic [31:0] num_mem_r [ENTRIES][MTC_WORDS];
  logic [31:0] num_mem_nxt [ENTRIES][MTC_WORDS];
  logic [15:0] ctype_r, ctype_nxt;
  logic [15:0] dest_r, dest_nxt;
  logic [15:0] src_r, src_nxt;
  logic [15:0] last_ctype_r, last_ctype_nxt;
  logic [15:0] last_dest_r, last_dest_nxt;
  logic [15:0] last_src_r, last_src_nxt;
  logic [15:0] tsel_r, tsel_nxt;
  logic [15:0] indir_r, indir_nxt;
  logic [7:0] disp_sel_r, disp_sel_nxt;
  logic disp_kind_r, disp_kind_nxt;
  logic [4:0] status_r, status_nxt;
  logic [6:0] cp_src_r, cp_src_nxt;
  logic [6:0] cp_dst_r, cp_dst_nxt;
  logic cp_kind_r, cp_kind_nxt;
  logic [MTC_WIDX_W-1:0] cp_word_r, cp_word_nxt;
  mtc_state_t state_r, state_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic disp_refresh_r, disp_refresh_nxt;

  logic setup, wr, rd, changed, type_ok;
  logic [8:0] d_dec, s_dec, t_dec, i_dec;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign disp_refresh = disp_refresh_r;
  assign disp_entry = disp_sel_r[6:0];
  assign disp_kind = disp_kind_r;

  // The slave answers one cycle after setup, so pready is registered.
  // Writes land at the access edge, where the master sees pready high.
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && pready_r;
  assign rd = setup && !pwrite;

  always_comb begin
    d_dec = bcd_decode(dest_r[11:0]);
    s_dec = bcd_decode(src_r[11:0]);
    // The table kind bit shares bit 11, so it is masked off the index.
    t_dec = bcd_decode({1'b0, tsel_r[10:0]});
    i_dec = bcd_decode(pwdata[11:0]);
    type_ok = (ctype_r == {12'h000, MTC_CT_STRING})
      || (ctype_r == {12'h000, MTC_CT_NUMERAL});
    // Any field differing from what was last acted on is a change. The
    // snapshot is taken every idle cycle, so a source written before the
    // destination may launch a copy early; hosts must order writes.
    changed = (ctype_r != last_ctype_r) || (dest_r != last_dest_r)
      || (src_r != last_src_r);
  end

  // Register writes and the copy sequencer.
  always_comb begin
    str_mem_nxt = str_mem_r;
    num_mem_nxt = num_mem_r;
    ctype_nxt = ctype_r;
    dest_nxt = dest_r;
    src_nxt = src_r;
    tsel_nxt = tsel_r;
    indir_nxt = indir_r;
    disp_sel_nxt = disp_sel_r;
    disp_kind_nxt = disp_kind_r;
    last_ctype_nxt = last_ctype_r;
    last_dest_nxt = last_dest_r;
    last_src_nxt = last_src_r;
    status_nxt = status_r;
    cp_src_nxt = cp_src_r;
    cp_dst_nxt = cp_dst_r;
    cp_kind_nxt = cp_kind_r;
    cp_word_nxt = cp_word_r;
    state_nxt = state_r;
    disp_refresh_nxt = 1'b0;
    if (wr) begin
      case (paddr)
        MTC_A_CTYPE: ctype_nxt = pwdata[15:0];
        MTC_A_DEST: dest_nxt = pwdata[15:0];
        MTC_A_SRC: src_nxt = pwdata[15:0];
        MTC_A_TSEL: tsel_nxt = pwdata[15:0];
        MTC_A_TDATA: begin
          // Table loading stands in for initialization-time fetches.
          if (t_dec[8] && state_r == MTC_IDLE) begin
            if (tsel_r[MTC_TSEL_KIND]) begin
              num_mem_nxt[t_dec[6:0]][tsel_r[15:12]] = pwdata;
            end else begin
              str_mem_nxt[t_dec[6:0]][tsel_r[15:12]] = pwdata;
            end
          end
        end
        MTC_A_INDIR: begin
          indir_nxt = pwdata[15:0];
          if (i_dec[8]) begin
            disp_sel_nxt = i_dec[7:0];
            disp_kind_nxt = pwdata[15];
            disp_refresh_nxt = 1'b1;
            status_nxt[MTC_ST_INDBAD] = 1'b0;
          end else begin
            status_nxt[MTC_ST_INDBAD] = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    case (state_r)
      MTC_IDLE: begin
        status_nxt[MTC_ST_BUSY] = 1'b0;
        if (changed) begin
          last_ctype_nxt = ctype_r;
          last_dest_nxt = dest_r;
          last_src_nxt = src_r;
          if (type_ok && d_dec[8] && s_dec[8]) begin
            cp_kind_nxt = ctype_r[0];
            cp_dst_nxt = d_dec[6:0];
            cp_src_nxt = s_dec[6:0];
            cp_word_nxt = '0;
            status_nxt[MTC_ST_BUSY] = 1'b1;
            status_nxt[MTC_ST_DONE] = 1'b0;
            status_nxt[MTC_ST_BADREQ] = 1'b0;
            state_nxt = MTC_COPY;
          end else begin
            status_nxt[MTC_ST_BADREQ] = 1'b1;
          end
        end
      end
      MTC_COPY: begin
        // Whole words are moved with no format check, so numeral entries
        // of different layouts may show wrongly after a copy.
        if (cp_kind_r) begin
          num_mem_nxt[cp_dst_r][cp_word_r] = num_mem_r[cp_src_r][cp_word_r];
        end else begin
          str_mem_nxt[cp_dst_r][cp_word_r] = str_mem_r[cp_src_r][cp_word_r];
        end
        cp_word_nxt = cp_word_r + 1'b1;
        if (cp_word_r == MTC_WIDX_W'(MTC_WORDS - 1)) begin
          state_nxt = MTC_REFRESH;
        end
      end
      MTC_REFRESH: begin
        // Only a display showing the destination is redrawn.
        if (disp_sel_r[6:0] == cp_dst_r && disp_kind_r == cp_kind_r) begin
          disp_refresh_nxt = 1'b1;
          status_nxt[MTC_ST_REFRESH] = 1'b1;
        end
        status_nxt[MTC_ST_DONE] = 1'b1;
        status_nxt[MTC_ST_BUSY] = 1'b0;
        state_nxt = MTC_IDLE;
      end
      default: state_nxt = MTC_IDLE;
    endcase
  end

  // APB answer path.
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    pready_nxt = setup;
    pslverr_nxt = 1'b0;
    if (setup) begin
      case (paddr)
        MTC_A_CTYPE: prdata_nxt = {16'h0000, ctype_r};
        MTC_A_DEST: prdata_nxt = {16'h0000, dest_r};
        MTC_A_SRC: prdata_nxt = {16'h0000, src_r};
        MTC_A_STATUS: prdata_nxt = {27'h0, status_r};
        MTC_A_TSEL: prdata_nxt = {16'h0000, tsel_r};
        MTC_A_TDATA: begin
          if (t_dec[8]) begin
            prdata_nxt = tsel_r[MTC_TSEL_KIND]
              ? num_mem_r[t_dec[6:0]][tsel_r[15:12]]
              : str_mem_r[t_dec[6:0]][tsel_r[15:12]];
          end
        end
        MTC_A_INDIR: prdata_nxt = {16'h0000, indir_r};
        MTC_A_DISP: prdata_nxt = {23'h0, disp_kind_r, disp_sel_r};
        default: pslverr_nxt = 1'b1;
      endcase
    end
    if (rd && paddr == MTC_A_TDATA && !t_dec[8]) begin
      pslverr_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int e = 0; e < ENTRIES; e++) begin
        for (int w = 0; w < MTC_WORDS; w++) begin
          str_mem_r[e][w] <= 32'h0000_0000;
          num_mem_r[e][w] <= 32'h0000_0000;
        end
      end
      ctype_r <= MTC_CTYPE_RST;
      dest_r <= 16'h0000;
      src_r <= 16'h0000;
      last_ctype_r <= MTC_CTYPE_RST;
      last_dest_r <= 16'h0000;
      last_src_r <= 16'h0000;
      tsel_r <= 16'h0000;
      indir_r <= 16'h0000;
      disp_sel_r <= 8'h00;
      disp_kind_r <= 1'b0;
      status_r <= 5'h00;
      cp_src_r <= 7'h00;
      cp_dst_r <= 7'h00;
      cp_kind_r <= 1'b0;
      cp_word_r <= '0;
      state_r <= MTC_IDLE;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      disp_refresh_r <= 1'b0;
    end else begin
      str_mem_r <= str_mem_nxt;
      num_mem_r <= num_mem_nxt;
      ctype_r <= ctype_nxt;
      dest_r <= dest_nxt;
      src_r <= src_nxt;
      last_ctype_r <= last_ctype_nxt;
      last_dest_r <= last_dest_nxt;
      last_src_r <= last_src_nxt;
      tsel_r <= tsel_nxt;
      indir_r <= indir_nxt;
      disp_sel_r <= disp_sel_nxt;
      disp_kind_r <= disp_kind_nxt;
      status_r <= status_nxt;
      cp_src_r <= cp_src_nxt;
      cp_dst_r <= cp_dst_nxt;
      cp_kind_r <= cp_kind_nxt;
      cp_word_r <= cp_word_nxt;
      state_r <= state_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      disp_refresh_r <= disp_refresh_nxt;
    end
  end

endmodule

// ==== test/mtc_copy_ctrl_properties.sv ====
// Checker for the copy controller's APB timing and display outputs.
// Assumes a bind to mtc_copy_ctrl; it sees only that module's ports.
`timescale 1ns/1ps
module mtc_chk
  import mtc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic disp_refresh,
  input wire logic [6:0] disp_entry
);
  // A redraw long after the last request or indirect write means a copy
  // ran by itself.
  logic [5:0] idle_r;
  logic [5:0] idle_nxt;
  always_comb begin
    idle_nxt = (idle_r == 6'h3F) ? idle_r : idle_r + 6'h01;
    if (psel && !penable && pwrite
      && (paddr <= MTC_A_SRC || paddr == MTC_A_INDIR)) begin
      idle_nxt = 6'h00;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_r <= 6'h3F;
    end else begin
      idle_r <= idle_nxt;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_only_access: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_err: assert property
    (psel && !penable && paddr > MTC_A_DISP |=> pslverr)
    else $error("unmapped address accepted");
  a_refresh_pulse: assert property (disp_refresh |=> !disp_refresh)
    else $error("redraw longer than one cycle");
  a_refresh_needs_req: assert property (disp_refresh |-> idle_r < 6'h28)
    else $error("redraw without a copy request");
  a_disp_from_write: assert property ($changed(disp_entry) |->
    $past(psel && pwrite && paddr[11:3] == 9'h003))
    else $error("display entry moved by itself");
endmodule
bind mtc_copy_ctrl mtc_chk i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .disp_refresh(disp_refresh),
  .disp_entry(disp_entry));

// ==== test/mtc_host.sv ====
// Host model: an APB master issuing one transfer per call of xfer.
// Assumes a free-running pclk and reset released before the first call.
`timescale 1ns/1ps
module mtc_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data is inverted so a stale value never looks valid.
    pwdata <= ~d;
  endtask
endmodule

// ==== test/test_mtc_copy_ctrl.sv ====
// Testbench for the copy controller: a reference table predicts reads.
// Assumes mtc_host and the checker are compiled before it.
`timescale 1ns/1ps
module test_mtc_copy_ctrl
  import mtc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic disp_refresh, disp_kind;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] disp_entry;
  int failures = 0, cmp_count = 0, ref_cnt = 0, cyc = 0, s, d, n;
  int tbl [2][128][16];
  mtc_copy_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .disp_refresh(disp_refresh), .disp_entry(disp_entry),
    .disp_kind(disp_kind));
  mtc_host i_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (disp_refresh === 1'b1) ref_cnt <= ref_cnt + 1;
    if (cyc == 5000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    i_host.xfer(1'b1, a, v, rd, err);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] v, logic e);
    i_host.xfer(1'b0, a, 32'h0000_0000, rd, err);
    chk(32'(err), 32'(e));
    if (!e) chk(rd, v);
  endtask
  task automatic wait_ref(input int m);
    for (int i = 0; i < 60 && ref_cnt == m; i++) @(posedge pclk);
    chk(32'(ref_cnt != m), 32'h0000_0001);
  endtask
  function automatic logic [11:0] bcd(input int v, input int k);
    return {4'(v / 100 + k * 8), 4'(v / 10 % 10), 4'(v % 10)};
  endfunction
  initial begin
    presetn = 1'b0;
    s = $urandom(20);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(MTC_A_CTYPE, {16'h0000, MTC_CTYPE_RST}, 1'b0);
    rdc(12'h020, 32'h0000_0000, 1'b1);
    for (int k = 0; k < 2; k++) begin
      s = k ? $urandom_range(126) : 0;
      d = k ? s + 1 : 127;
      wr(MTC_A_CTYPE, 32'h0000_9999);
      for (int w = 0; w < 16; w++) begin
        tbl[k][s][w] = $urandom;
        wr(MTC_A_TSEL, {16'h0000, 4'(w), bcd(s, k)});
        wr(MTC_A_TDATA, tbl[k][s][w]);
      end
      wr(MTC_A_INDIR, {16'h0000, 1'(k), 3'h0, bcd(d, 0)});
      repeat (2) @(posedge pclk);
      chk(32'(disp_entry), 32'(d));
      chk(32'(disp_kind), 32'(k));
      n = ref_cnt;
      wr(MTC_A_DEST, 32'(bcd(d, 0)));
      wr(MTC_A_SRC, 32'(bcd(s, 0)));
      wr(MTC_A_CTYPE, 32'(k));
      wait_ref(n);
      for (int w = 0; w < 16; w++) begin
        tbl[k][d][w] = tbl[k][s][w];
        wr(MTC_A_TSEL, {16'h0000, 4'(w), bcd(d, k)});
        rdc(MTC_A_TDATA, tbl[k][d][w], 1'b0);
      end
      n = ref_cnt;
      wr(MTC_A_CTYPE, 32'(k));
      wr(MTC_A_CTYPE, 32'h0000_0002);
      repeat (40) @(posedge pclk);
      chk(32'(ref_cnt), 32'(n));
      i_host.xfer(1'b0, MTC_A_STATUS, 32'h0000_0000, rd, err);
      chk(32'(rd[MTC_ST_BADREQ]), 32'h0000_0001);
      wr(MTC_A_CTYPE, 32'(k));
      wait_ref(n);
    end
    wr(MTC_A_INDIR, 32'h0000_00A5);
    repeat (2) @(posedge pclk);
    chk(32'(disp_entry), 32'(d));
    give_verdict();
  end
endmodule
